// *** bench/msc_mode_strap_config_latch_assertions.sv ***
// concurrent checks on the strap latch ports
`timescale 1ns/1ps
module msc_cfg_assertions
	import msc_pkg::*;
(
	input wire logic        i_sys_clk,
	input wire logic        i_rst_b,
	input wire logic [7:0]  i_reg_addr,
	input wire logic        i_reg_wr,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic        i_reg_rd,
	input wire logic [7:0]  o_reg_rdata,
	input wire logic        o_reg_rvalid,
	input wire logic [17:0] i_pixel_freq_khz,
	input wire logic        i_legacy_receiver,
	input wire logic        i_dvi_mode,
	input wire logic [11:0] i_ssc_dev_cpct,
	input wire logic        o_config_ready,
	input wire logic        o_remote_id_search,
	input wire logic        o_local_id_use,
	input wire logic [7:0]  o_remote_id_address,
	input wire logic        o_aux_audio_enable,
	input wire logic        o_external_control,
	input wire logic        o_coaxial_cable,
	input wire logic        o_remote_id_copy,
	input wire logic        o_secondary_tx_enable,
	input wire logic        o_back_channel_enable,
	input wire logic        o_hscc_enable,
	input wire logic        o_video_freq_ok,
	input wire logic        o_ssc_in_range
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	// write accepted once the capture is over
	sequence s_wr(logic [7:0] a);
		o_config_ready && i_reg_wr && i_reg_addr == a ##1 !i_reg_wr;
	endsequence
	property p_rd;
		i_reg_rd |=> o_reg_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("no read answer");
	property p_back;
		s_wr(ADDR_BRIDGE_CONFIGURATION) ##1 i_reg_rd && !i_reg_wr &&
		i_reg_addr == ADDR_BRIDGE_CONFIGURATION
		|=> o_reg_rdata == $past(i_reg_wdata, 3);
	endproperty
	a_back: assert property (p_back) else $error("bad readback");
	property p_cfg;
		s_wr(ADDR_BRIDGE_CONFIGURATION) |=>
		o_aux_audio_enable == $past(i_reg_wdata[1], 2) &&
		o_external_control == $past(i_reg_wdata[7], 2) &&
		o_remote_id_copy == $past(i_reg_wdata[5], 2);
	endproperty
	a_cfg: assert property (p_cfg) else $error("cfg out");
	property p_id;
		s_wr(ADDR_BRIDGE_CONTROL) |=> o_local_id_use ==
		$past(i_reg_wdata[0], 2) && o_remote_id_search != o_local_id_use;
	endproperty
	a_id: assert property (p_id) else $error("id source");
	property p_cable_type_select;
		s_wr(ADDR_DUAL_LINK_CONTROL) |=>
		o_coaxial_cable == $past(i_reg_wdata[7], 2);
	endproperty
	a_cable_type_select: assert property (p_cable_type_select) else $error("cable");
	property p_force;
		s_wr(ADDR_DUAL_LINK_CONTROL) ##0
		$past(i_reg_wdata[2:0]) == FORCE_SINGLE_CODE |=>
		!o_secondary_tx_enable && !o_back_channel_enable && !o_hscc_enable;
	endproperty
	a_force: assert property (p_force) else $error("single");
	property p_addr;
		i_reg_wr && i_reg_addr == ADDR_REMOTE_ID_ADDRESS ##1 !i_reg_wr
		|=> o_remote_id_address == $past(i_reg_wdata, 2);
	endproperty
	a_addr: assert property (p_addr) else $error("id address");
	property p_quiet;
		!o_config_ready |-> !o_aux_audio_enable && !o_external_control &&
		!o_coaxial_cable && !o_remote_id_copy;
	endproperty
	a_quiet: assert property (p_quiet) else $error("early cfg");
	property p_hold;
		(o_config_ready && !i_reg_wr) [*3] |->
		$stable(o_external_control) && $stable(o_coaxial_cable);
	endproperty
	a_hold: assert property (p_hold) else $error("cfg moved");
	property p_single;
		o_config_ready && !i_legacy_receiver &&
		i_pixel_freq_khz <= SINGLE_MAX_KHZ |=> o_video_freq_ok;
	endproperty
	a_single: assert property (p_single) else $error("freq");
	property p_legacy;
		i_legacy_receiver && i_pixel_freq_khz >= LEGACY_MAX_KHZ
		|=> !o_video_freq_ok;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy");
	property p_ssc;
		!i_dvi_mode || i_ssc_dev_cpct > SSC_DEV_MAX_CPCT |=> !o_ssc_in_range;
	endproperty
	a_ssc: assert property (p_ssc) else $error("spread");
endmodule

// *** bench/msc_mode_strap_config_latch_tb_top.sv ***
// self-checking bench for the mode strap configuration latch
`timescale 1ns/1ps
module msc_mode_strap_config_latch_tb_top
	import msc_pkg::*;
();
	logic i_sys_clk, i_rst_b, i_reg_wr, i_reg_rd, i_legacy_receiver;
	logic i_rx_hscc_capable, i_dvi_mode, o_reg_rvalid, o_config_ready;
	logic o_remote_id_search, o_local_id_use, o_aux_audio_enable;
	logic o_external_control, o_coaxial_cable, o_remote_id_copy;
	logic o_secondary_tx_enable, o_back_channel_enable, o_hscc_enable;
	logic o_video_freq_ok, o_ssc_in_range;
	logic [7:0] i_config_strap_input_0, i_config_strap_input_1;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_remote_id_address;
	logic [17:0] i_pixel_freq_khz;
	logic [11:0] i_ssc_dev_cpct, i_ssc_rate_khz;
	logic [1:0] sel0;
	logic [2:0] sel1;
	int mismatches, compares;
	localparam logic [11:0] D = SSC_DEV_MAX_CPCT;
	localparam logic [11:0] R = SSC_RATE_MAX_KHZ;
	logic [11:0] dv [5] = '{D, D / 2, D, D + 1, D / 2};
	logic [11:0] rt [5] = '{R / 2, R, R, 12'h000, R / 2};

	// short settle keeps each boot brief
	localparam int SETTLE = 2;

	msc_mode_strap_config_latch #(
		.SETTLE_CYC (SETTLE)
	) msc_mode_strap_config_latch_i (
		.i_sys_clk              (i_sys_clk),
		.i_rst_b                (i_rst_b),
		.i_config_strap_input_0 (i_config_strap_input_0),
		.i_config_strap_input_1 (i_config_strap_input_1),
		.i_reg_addr             (i_reg_addr),
		.i_reg_wr               (i_reg_wr),
		.i_reg_wdata            (i_reg_wdata),
		.i_reg_rd               (i_reg_rd),
		.o_reg_rdata            (o_reg_rdata),
		.o_reg_rvalid           (o_reg_rvalid),
		.i_pixel_freq_khz       (i_pixel_freq_khz),
		.i_legacy_receiver      (i_legacy_receiver),
		.i_rx_hscc_capable      (i_rx_hscc_capable),
		.i_dvi_mode             (i_dvi_mode),
		.i_ssc_dev_cpct         (i_ssc_dev_cpct),
		.i_ssc_rate_khz         (i_ssc_rate_khz),
		.o_config_ready         (o_config_ready),
		.o_remote_id_search     (o_remote_id_search),
		.o_local_id_use         (o_local_id_use),
		.o_remote_id_address    (o_remote_id_address),
		.o_aux_audio_enable     (o_aux_audio_enable),
		.o_external_control     (o_external_control),
		.o_coaxial_cable        (o_coaxial_cable),
		.o_remote_id_copy       (o_remote_id_copy),
		.o_secondary_tx_enable  (o_secondary_tx_enable),
		.o_back_channel_enable  (o_back_channel_enable),
		.o_hscc_enable          (o_hscc_enable),
		.o_video_freq_ok        (o_video_freq_ok),
		.o_ssc_in_range         (o_ssc_in_range)
	);
	msc_strap_model msc_strap_model_i (
		.i_sel0    (sel0),
		.i_sel1    (sel1),
		.o_strap_0 (i_config_strap_input_0),
		.o_strap_1 (i_config_strap_input_1)
	);
	always #2.5 i_sys_clk = ~i_sys_clk;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_sys_clk);
		i_reg_wr = 1'b0;
		@(negedge i_sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		int n;
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		@(negedge i_sys_clk);
		i_reg_rd = 1'b0;
		n = 0;
		while (o_reg_rvalid !== 1'b1 && n < 3)
		begin
			@(negedge i_sys_clk);
			n++;
		end
		chk({o_reg_rvalid, o_reg_rdata}, {1'b1, e});
		@(negedge i_sys_clk);
	endtask
	// local, search, aux, ext, cable_type_select, copy
	task automatic outs(input logic [5:0] e);
		chk({3'h0, o_local_id_use, o_remote_id_search, o_aux_audio_enable,
			o_external_control, o_coaxial_cable, o_remote_id_copy},
			{3'h0, e});
	endtask
	task automatic boot(input logic [1:0] k, input logic [2:0] m);
		int n;
		sel0 = k;
		sel1 = m;
		i_rst_b = 1'b0;
		repeat (8) @(negedge i_sys_clk);
		i_rst_b = 1'b1;
		n = 0;
		while (o_config_ready !== 1'b1 && n < 40)
		begin
			@(negedge i_sys_clk);
			n++;
		end
		chk({o_config_ready, 8'(n)}, {1'b1, 8'(SETTLE + 1)});
		repeat (2) @(negedge i_sys_clk);
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog and test sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (5000) @(posedge i_sys_clk);
		mismatches++;
		finish_test();
	end
	initial
	begin
		{i_sys_clk, i_rst_b, i_reg_wr, i_reg_rd, i_dvi_mode} = 5'h00;
		{i_legacy_receiver, i_rx_hscc_capable, sel0, sel1} = 7'h00;
		{i_reg_addr, i_reg_wdata, i_pixel_freq_khz} = 34'h0;
		{i_ssc_dev_cpct, i_ssc_rate_khz} = 24'h000;
		for (int i = 0; i < 8; i++)
		begin
			// strap 1 bits differ from strap 0 bits so field swaps show
			boot(i[1:0], {i[2], i[1] ^ i[0], ~i[0]});
			rd(ADDR_BRIDGE_CONTROL, {7'h00, i[1]});
			rd(ADDR_BRIDGE_CONFIGURATION, {i[2], 1'b0, ~i[0], 3'h0, i[0],
				1'b0});
			rd(ADDR_DUAL_LINK_CONTROL, {i[1] ^ i[0], 7'h00});
			sel0 = ~i[1:0];
			sel1 = ~i[2:0];
			repeat (6) @(negedge i_sys_clk);
			outs({i[1], ~i[1], i[0], i[2], i[1] ^ i[0], ~i[0]});
		end
		rd(ADDR_REMOTE_ID_ADDRESS, RST_REMOTE_ID_ADDRESS);
		chk({7'h00, o_secondary_tx_enable, o_hscc_enable}, 9'h002);
		$display("strap capture test done");
		i_rx_hscc_capable = 1'b1;
		wr(ADDR_BRIDGE_CONTROL, 8'h00);
		wr(ADDR_BRIDGE_CONFIGURATION, 8'h20);
		rd(ADDR_BRIDGE_CONFIGURATION, 8'h20);
		wr(ADDR_DUAL_LINK_CONTROL, 8'h04);
		outs(6'h11);
		chk({6'h00, o_secondary_tx_enable, o_back_channel_enable,
			o_hscc_enable}, 9'h000);
		wr(ADDR_DUAL_LINK_CONTROL, 8'h80);
		chk({5'h00, o_coaxial_cable, o_secondary_tx_enable,
			o_back_channel_enable, o_hscc_enable}, 9'h00F);
		rd(8'h33, 8'h00);
		wr(ADDR_REMOTE_ID_ADDRESS, 8'h5C);
		rd(ADDR_REMOTE_ID_ADDRESS, 8'h5C);
		chk({1'b0, o_remote_id_address}, 9'h05C);
		$display("override test done");
		for (int j = 0; j < 4; j++)
		begin
			i_legacy_receiver = j[1];
			i_pixel_freq_khz = j[1] ? LEGACY_MAX_KHZ - 18'(1 - j[0])
				: SINGLE_MAX_KHZ + 18'(j[0]);
			repeat (2) @(negedge i_sys_clk);
			chk({8'h00, o_video_freq_ok}, {8'h00, ~j[0]});
		end
		$display("frequency test done");
		for (int j = 0; j < 5; j++)
		begin
			i_dvi_mode = (j < 4);
			i_ssc_dev_cpct = dv[j];
			i_ssc_rate_khz = rt[j];
			repeat (2) @(negedge i_sys_clk);
			chk({8'h00, o_ssc_in_range}, {8'h00, j < 2});
		end
		$display("spread spectrum test done");
		finish_test();
	end
endmodule

bind msc_mode_strap_config_latch msc_cfg_assertions msc_cfg_assertions_i (
	.i_sys_clk             (i_sys_clk),
	.i_rst_b               (i_rst_b),
	.i_reg_addr            (i_reg_addr),
	.i_reg_wr              (i_reg_wr),
	.i_reg_wdata           (i_reg_wdata),
	.i_reg_rd              (i_reg_rd),
	.o_reg_rdata           (o_reg_rdata),
	.o_reg_rvalid          (o_reg_rvalid),
	.i_pixel_freq_khz      (i_pixel_freq_khz),
	.i_legacy_receiver     (i_legacy_receiver),
	.i_dvi_mode            (i_dvi_mode),
	.i_ssc_dev_cpct        (i_ssc_dev_cpct),
	.o_config_ready        (o_config_ready),
	.o_remote_id_search    (o_remote_id_search),
	.o_local_id_use        (o_local_id_use),
	.o_remote_id_address   (o_remote_id_address),
	.o_aux_audio_enable    (o_aux_audio_enable),
	.o_external_control    (o_external_control),
	.o_coaxial_cable       (o_coaxial_cable),
	.o_remote_id_copy      (o_remote_id_copy),
	.o_secondary_tx_enable (o_secondary_tx_enable),
	.o_back_channel_enable (o_back_channel_enable),
	.o_hscc_enable         (o_hscc_enable),
	.o_video_freq_ok       (o_video_freq_ok),
	.o_ssc_in_range        (o_ssc_in_range)
);

// *** bench/msc_strap_model.sv ***
// strap divider model: level index in, ratio code out
`timescale 1ns/1ps
module msc_strap_model
	import msc_pkg::*;
(
	input  wire logic [1:0] i_sel0,
	input  wire logic [2:0] i_sel1,
	output logic      [7:0] o_strap_0,
	output logic      [7:0] o_strap_1
);
	// ----------------------------------------------------------------
	// divider ratios of the strap levels
	// ----------------------------------------------------------------
	localparam logic [8:0] LV0 [4] = '{LVL_0000, LVL_0208, LVL_0553,
		LVL_0668};
	localparam logic [8:0] LV1 [8] = '{LVL_0000, LVL_0208, LVL_0323,
		LVL_0440, LVL_0553, LVL_0668, LVL_0789, LVL_1000};
	// pin voltage as seen by the strap sampler
	assign o_strap_0 = LV0[i_sel0][7:0];
	assign o_strap_1 = LV1[i_sel1][7:0];
endmodule

// *** rtl/msc_mode_strap_config_latch.sv ***
// power-up strap decode, configuration registers and single-link control
// Function
// - config from straps or software register bits
// - capture decoded straps into registers at power-up
// - strap 0 four levels give two bits
// - strap 1 eight levels give n-1
// - id select picks remote search or local
// - remote id address defaults, software replaceable
// - aux audio bit adds auxiliary audio channel
// - override bit hands control to external controller
// - cable bit selects twisted pair or cable_type_select
// - copy bit loads remote id into sram
// - id select stored in bridge control bit0
// - aux audio stored in configuration bit1
// - override stored in configuration bit7
// - cable type stored in dual control bit7
// - remote copy stored in configuration bit5
// - latched fields readable and writable by software
// - single link carries 24-bit video to 105 MHz
// - legacy receivers only below 85 MHz
// - secondary link may carry high-speed control
// - forced single disables secondary phy, back channel
// - in DVI mode only, tolerate triangular spread clock, not both maxima
`timescale 1ns/1ps
module msc_mode_strap_config_latch
	import msc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = STRAP_SETTLE_CYC
)(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic [7:0]  i_config_strap_input_0,
	input  wire logic [7:0]  i_config_strap_input_1,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_rd,
	output logic [7:0]       o_reg_rdata,
	output logic             o_reg_rvalid,
	input  wire logic [17:0] i_pixel_freq_khz,
	input  wire logic        i_legacy_receiver,
	input  wire logic        i_rx_hscc_capable,
	input  wire logic        i_dvi_mode,
	input  wire logic [11:0] i_ssc_dev_cpct,
	input  wire logic [11:0] i_ssc_rate_khz,
	output logic             o_config_ready,
	output logic             o_remote_id_search,
	output logic             o_local_id_use,
	output logic [7:0]       o_remote_id_address,
	output logic             o_aux_audio_enable,
	output logic             o_external_control,
	output logic             o_coaxial_cable,
	output logic             o_remote_id_copy,
	output logic             o_secondary_tx_enable,
	output logic             o_back_channel_enable,
	output logic             o_hscc_enable,
	output logic             o_video_freq_ok,
	output logic             o_ssc_in_range
);

	// ----------------------------------------------------------------
	// spread spectrum limit
	// ----------------------------------------------------------------
	// weight 2*dev + 5*rate scores 500 for either maximum alone; the
	// limit allows full deviation with half the rate, or the reverse
	localparam logic [13:0] SSC_WEIGHT_MAX =
		14'(2 * SSC_DEV_MAX_CPCT + (5 * SSC_RATE_MAX_KHZ) / 2);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] s0_meta_reg;
	logic [7:0] s0_sync_reg;
	logic [7:0] s1_meta_reg;
	logic [7:0] s1_sync_reg;
	msc_state_t state_reg;
	logic [15:0] settle_cnt_reg;
	logic [1:0] strap0_bits;
	logic [2:0] strap1_bits;
	logic [7:0] bridge_control_reg;
	logic [7:0] bridge_configuration_reg;
	logic [7:0] dual_link_control_reg;
	logic [7:0] remote_id_address_reg;
	logic       capture;
	logic       forced_single;
	logic [13:0] ssc_weight;
	logic [8:0] code0;
	logic [8:0] code1;

	// ----------------------------------------------------------------
	// strap synchronisers
	// ----------------------------------------------------------------
	// two stages before any decode reads the pins; the straps are
	// static resistor levels, so bits of a code arriving one edge
	// apart do no harm: the settle count outlasts that skew
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			s0_meta_reg <= 8'h00;
			s0_sync_reg <= 8'h00;
			s1_meta_reg <= 8'h00;
			s1_sync_reg <= 8'h00;
		end
		else
		begin
			s0_meta_reg <= i_config_strap_input_0;
			s0_sync_reg <= s0_meta_reg;
			s1_meta_reg <= i_config_strap_input_1;
			s1_sync_reg <= s1_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// level decode, thresholds midway between adjacent levels
	// ----------------------------------------------------------------
	// codes widened to the width of the level constants; twice the
	// code against the sum of two levels is a midpoint compare
	assign code0 = {1'b0, s0_sync_reg};
	assign code1 = {1'b0, s1_sync_reg};

	// strap 0: four levels to id select and aux audio
	always_comb
	begin
		if (2 * code0 < LVL_0000 + LVL_0208)
			strap0_bits = 2'h0;
		else if (2 * code0 < LVL_0208 + LVL_0553)
			strap0_bits = 2'h1;
		else if (2 * code0 < LVL_0553 + LVL_0668)
			strap0_bits = 2'h2;
		else
			strap0_bits = 2'h3;
	end

	// strap 1: level n gives n-1
	always_comb
	begin
		if (2 * code1 < LVL_0000 + LVL_0208)
			strap1_bits = 3'h0;
		else if (2 * code1 < LVL_0208 + LVL_0323)
			strap1_bits = 3'h1;
		else if (2 * code1 < LVL_0323 + LVL_0440)
			strap1_bits = 3'h2;
		else if (2 * code1 < LVL_0440 + LVL_0553)
			strap1_bits = 3'h3;
		else if (2 * code1 < LVL_0553 + LVL_0668)
			strap1_bits = 3'h4;
		else if (2 * code1 < LVL_0668 + LVL_0789)
			strap1_bits = 3'h5;
		else if (2 * code1 < LVL_0789 + LVL_1000)
			strap1_bits = 3'h6;
		else
			strap1_bits = 3'h7;
	end

	// ----------------------------------------------------------------
	// power-up capture sequencer
	// ----------------------------------------------------------------
	// wait for straps to settle, capture once, then never again
	// the sequencer parks in run, so later strap moves are ignored
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			state_reg      <= MSC_SETTLE;
			settle_cnt_reg <= 16'h0000;
		end
		else
		begin
			unique case (state_reg)
				MSC_SETTLE:
				begin
					settle_cnt_reg <= settle_cnt_reg + 16'h0001;
					if (settle_cnt_reg == 16'(SETTLE_CYC - 1))
						state_reg <= MSC_CAPTURE;
				end
				MSC_CAPTURE:
					state_reg <= MSC_RUN;
				MSC_RUN:
					state_reg <= MSC_RUN;
				default:
					state_reg <= MSC_SETTLE;
			endcase
		end
	end

	// capture is the one cycle in which the straps, not software,
	// decide the strap fields; afterwards only writes change them
	assign capture        = (state_reg == MSC_CAPTURE);
	assign o_config_ready = (state_reg == MSC_RUN);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// bridge control: capture wins over a write in the same cycle
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			bridge_control_reg <= RST_BRIDGE_CONTROL;
		else if (capture)
			bridge_control_reg[POS_DISPLAY_ID_DISABLE] <= strap0_bits[1];
		else if (i_reg_wr && i_reg_addr == ADDR_BRIDGE_CONTROL)
			bridge_control_reg <= i_reg_wdata;
	end

	// bridge configuration: audio mode, remote copy, override
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			bridge_configuration_reg <= RST_BRIDGE_CONFIGURATION;
		else if (capture)
		begin
			bridge_configuration_reg[POS_AUDIO_MODE]       <= strap0_bits[0];
			bridge_configuration_reg[POS_EXTERNAL_CONTROL] <= strap1_bits[2];
			bridge_configuration_reg[POS_REMOTE_ID_COPY]   <= strap1_bits[0];
		end
		else if (i_reg_wr && i_reg_addr == ADDR_BRIDGE_CONFIGURATION)
			bridge_configuration_reg <= i_reg_wdata;
	end

	// dual link control: cable type and link mode
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			dual_link_control_reg <= RST_DUAL_LINK_CONTROL;
		else if (capture)
			dual_link_control_reg[POS_COAXIAL_CABLE] <= strap1_bits[1];
		else if (i_reg_wr && i_reg_addr == ADDR_DUAL_LINK_CONTROL)
			dual_link_control_reg <= i_reg_wdata;
	end

	// remote display id bus address
	// not a strap field, so the capture leaves it alone
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			remote_id_address_reg <= RST_REMOTE_ID_ADDRESS;
		else if (i_reg_wr && i_reg_addr == ADDR_REMOTE_ID_ADDRESS)
			remote_id_address_reg <= i_reg_wdata;
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	// one-cycle read latency, unmapped offsets read zero
	// reads have no side effect on any field
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
			begin
				unique case (i_reg_addr)
					ADDR_BRIDGE_CONTROL:       o_reg_rdata <= bridge_control_reg;
					ADDR_BRIDGE_CONFIGURATION:
						o_reg_rdata <= bridge_configuration_reg;
					ADDR_DUAL_LINK_CONTROL:    o_reg_rdata <= dual_link_control_reg;
					ADDR_REMOTE_ID_ADDRESS:    o_reg_rdata <= remote_id_address_reg;
					default:                   o_reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration outputs, driven by register fields, and by i_rx_hscc_capable for o_hscc_enable
	// ----------------------------------------------------------------
	// forced single turns off the secondary transmitter and its
	// back channel; every other link mode code leaves them on
	assign forced_single =
		(dual_link_control_reg[2:0] == FORCE_SINGLE_CODE);

	// registered so outputs change one cycle after the field
	// gating by ready holds every output but o_remote_id_address low until the capture
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_remote_id_search    <= 1'b0;
			o_local_id_use        <= 1'b0;
			o_remote_id_address   <= RST_REMOTE_ID_ADDRESS;
			o_aux_audio_enable    <= 1'b0;
			o_external_control    <= 1'b0;
			o_coaxial_cable       <= 1'b0;
			o_remote_id_copy      <= 1'b0;
			o_secondary_tx_enable <= 1'b0;
			o_back_channel_enable <= 1'b0;
			o_hscc_enable         <= 1'b0;
		end
		else
		begin
			o_remote_id_search <= o_config_ready &&
				!bridge_control_reg[POS_DISPLAY_ID_DISABLE];
			o_local_id_use <= o_config_ready &&
				bridge_control_reg[POS_DISPLAY_ID_DISABLE];
			o_remote_id_address <= remote_id_address_reg;
			o_aux_audio_enable <= o_config_ready &&
				bridge_configuration_reg[POS_AUDIO_MODE];
			o_external_control <= o_config_ready &&
				bridge_configuration_reg[POS_EXTERNAL_CONTROL];
			o_coaxial_cable <= o_config_ready &&
				dual_link_control_reg[POS_COAXIAL_CABLE];
			o_remote_id_copy <= o_config_ready &&
				bridge_configuration_reg[POS_REMOTE_ID_COPY];
			o_secondary_tx_enable <= o_config_ready && !forced_single;
			o_back_channel_enable <= o_config_ready && !forced_single;
			o_hscc_enable <= o_config_ready && !forced_single &&
				i_rx_hscc_capable;
		end
	end

	// ----------------------------------------------------------------
	// frequency and spread spectrum checks
	// ----------------------------------------------------------------
	// combined weight: full deviation counts 500, full rate counts 500
	assign ssc_weight = 14'(2 * i_ssc_dev_cpct) + 14'(5 * i_ssc_rate_khz);

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_video_freq_ok <= 1'b0;
			o_ssc_in_range  <= 1'b0;
		end
		else
		begin
			// legacy receivers need a lower ceiling
			o_video_freq_ok <= i_legacy_receiver ?
				(i_pixel_freq_khz < LEGACY_MAX_KHZ) :
				(i_pixel_freq_khz <= SINGLE_MAX_KHZ);
			// both maxima together are out of range
			o_ssc_in_range <= i_dvi_mode &&
				(i_ssc_dev_cpct <= SSC_DEV_MAX_CPCT) &&
				(i_ssc_rate_khz <= SSC_RATE_MAX_KHZ) &&
				(ssc_weight <= SSC_WEIGHT_MAX);
		end
	end

endmodule

// *** rtl/msc_pkg.sv ***
// constants of the mode strap configuration latch
package msc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_MHZ    = 200;
	localparam int unsigned STRAP_SETTLE_NS = 100;
	localparam int unsigned STRAP_SETTLE_CYC =
		(STRAP_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_BRIDGE_CONTROL       = 8'h4F;
	localparam logic [7:0] ADDR_BRIDGE_CONFIGURATION = 8'h54;
	localparam logic [7:0] ADDR_DUAL_LINK_CONTROL    = 8'h5B;
	localparam logic [7:0] ADDR_REMOTE_ID_ADDRESS    = 8'h70;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned POS_DISPLAY_ID_DISABLE  = 0;
	localparam int unsigned POS_AUDIO_MODE          = 1;
	localparam int unsigned POS_REMOTE_ID_COPY      = 5;
	localparam int unsigned POS_EXTERNAL_CONTROL    = 7;
	localparam int unsigned POS_COAXIAL_CABLE       = 7;
	localparam logic [2:0]  FORCE_SINGLE_CODE       = 3'h4;
	localparam logic [7:0]  RST_BRIDGE_CONTROL      = 8'h00;
	localparam logic [7:0]  RST_BRIDGE_CONFIGURATION = 8'h00;
	localparam logic [7:0]  RST_DUAL_LINK_CONTROL   = 8'h00;
	localparam logic [7:0]  RST_REMOTE_ID_ADDRESS   = 8'hA0;

	// ----------------------------------------------------------------
	// strap levels as 8-bit ratio codes (ratio times 255)
	// ----------------------------------------------------------------
	localparam logic [8:0] LVL_0000 = 9'h000;
	localparam logic [8:0] LVL_0208 = 9'h035;
	localparam logic [8:0] LVL_0323 = 9'h052;
	localparam logic [8:0] LVL_0440 = 9'h070;
	localparam logic [8:0] LVL_0553 = 9'h08D;
	localparam logic [8:0] LVL_0668 = 9'h0AA;
	localparam logic [8:0] LVL_0789 = 9'h0C9;
	localparam logic [8:0] LVL_1000 = 9'h0FF;

	// ----------------------------------------------------------------
	// link frequency and spread spectrum limits
	// ----------------------------------------------------------------
	localparam logic [17:0] SINGLE_MAX_KHZ  = 18'h19A28; // 105000 kHz
	localparam logic [17:0] LEGACY_MAX_KHZ  = 18'h14C08; // 85000 kHz
	localparam logic [11:0] SSC_DEV_MAX_CPCT = 12'h0FA; // 2.50 %
	localparam logic [11:0] SSC_RATE_MAX_KHZ = 12'h064; // 100 kHz

	// capture sequencer states
	typedef enum logic [1:0] {
		MSC_SETTLE  = 2'b00,
		MSC_CAPTURE = 2'b01,
		MSC_RUN     = 2'b10
	} msc_state_t;

endpackage
